/* rtl/csi_tx_ctl_pkg.sv */
/*
  Constants, field layout and bus carriers for the transmit-port control and
  status bank. Assumes a 32-bit AXI4-Lite master with an 8-bit byte address.
*/
package csi_tx_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [5:0]  IDX_CTL_TWO   = 6'h34;
  localparam logic [5:0]  IDX_STATUS    = 6'h35;
  localparam logic [5:0]  IDX_INT_EN    = 6'h36;
  localparam logic [5:0]  IDX_INT_FLAGS = 6'h37;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         BIT_PERIODIC   = 0;
  localparam int         BIT_SINGLE     = 1;
  localparam int         BIT_INVERT     = 2;
  localparam int         BIT_PASS_ALL   = 3;
  localparam logic [3:0] CTL_TWO_RSVD   = 4'h4;
  localparam int         BIT_PASS       = 0;
  localparam int         BIT_ALIGN      = 1;
  localparam int         EV_VALID_GAIN  = 0;
  localparam int         EV_VALID_LOSS  = 1;
  localparam int         EV_ALIGN_REACH = 2;
  localparam int         EV_ALIGN_FAULT = 3;
  localparam int         EV_RX_PORT     = 4;
  localparam int         NUM_EV         = 5;
  localparam int         NUM_RX         = 2;
  localparam logic [NUM_EV-1:0] IE_RESET   = 5'h00;
  localparam logic [NUM_EV-1:0] CLR_ON_RD  = 5'h0F;

  // Deskew burst patterns, first transmitted bit in the MSB
  localparam logic [7:0] PATTERN_NORMAL = 8'h55;
  localparam logic [7:0] PATTERN_INVERT = 8'hAA;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    DESKEW_IDLE  = 1'b0,
    DESKEW_BURST = 1'b1
  } deskew_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage : csi_tx_ctl_pkg

/* rtl/csi_tx_status_deskew_irq_ctl.sv */
/*
  Control and status bank of the video transmit port: pass indication scope,
  deskew burst scheduling, alignment and valid-video status, event flags and
  their interrupt enables, reached over AXI4-Lite.
  Assumes every status input comes from logic on core_clk, that the
  transmitter acknowledges a burst with a one-cycle done pulse, and that the
  receive-port event is cleared by that port's own status logic.
  Only byte lane 0 carries data; writes to status and flags are ignored.
*/
// Operation
// - Scope clear: pass on any enabled port
// - Scope set: pass only when all valid
// - Default burst pattern is 01010101
// - Invert bit sends 10101010 instead
// - One-shot write emits exactly one burst
// - One-shot burst waits for link idle
// - One-shot bit self-clears after burst
// - Periodic bit: burst after each frame end
// - Aligned status zero when sync disabled
// - Aligned status follows stream alignment
// - Unsynced: valid means actively delivering
// - Unsynced: interrupting error clears valid-video status
// - Synced: valid means data ready only
// - Enable gates receive-port event
// - Enable gates alignment-reached event
// - Enable gates valid-video gain event
// - Enable gates valid-loss event
// - Enable gates alignment-fault event
// - Port valid drop latches loss, read clears
// - Alignment failure latches fault flag when synced
// - Port event cleared at port, not here
`timescale 1ns/1ps
module csi_tx_status_deskew_irq_ctl (
  input  wire logic                              core_clk,        // 50 MHz clock
  input  wire logic                              reset_n,         // Synchronous reset
  input  wire csi_tx_ctl_pkg::axil_req_s         axil_req,        // Bus request channels
  output csi_tx_ctl_pkg::axil_rsp_s              axil_rsp,        // Bus response channels
  input  wire logic [csi_tx_ctl_pkg::NUM_RX-1:0] rx_port_enable,  // Ports forwarded here
  input  wire logic [csi_tx_ctl_pkg::NUM_RX-1:0] rx_port_valid,   // Port delivers valid video
  input  wire logic                              sync_enable,     // Synchronized forwarding on
  input  wire logic                              align_ok,        // Streams currently aligned
  input  wire logic                              align_fail,      // Alignment failure pulse
  input  wire logic                              tx_error,        // Interrupting error pulse
  input  wire logic                              rx_port_event,   // Port event level
  input  wire logic                              frame_end_sent,  // Frame End sent pulse
  input  wire logic                              link_idle,       // Output between packets
  input  wire logic                              deskew_done,     // Burst finished pulse
  output logic                                   deskew_req,      // Send a burst
  output logic [7:0]                             deskew_pattern,  // Burst byte
  output logic                                   irq              // Interrupt request
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  function automatic logic [5:0] reg_index(input logic [csi_tx_ctl_pkg::ADDR_W-1:0] a);
    reg_index = a[csi_tx_ctl_pkg::ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic mapped(input logic [5:0] i);
    mapped = (i == csi_tx_ctl_pkg::IDX_CTL_TWO) || (i == csi_tx_ctl_pkg::IDX_STATUS) ||
             (i == csi_tx_ctl_pkg::IDX_INT_EN)  || (i == csi_tx_ctl_pkg::IDX_INT_FLAGS);
  endfunction : mapped

  csi_tx_ctl_pkg::axil_rsp_s               rsp_q;
  logic [csi_tx_ctl_pkg::ADDR_W-1:0]       awaddr_q;
  logic [7:0]                              wbyte_q;
  logic                                    wlane_q;
  logic                                    have_aw_q;
  logic                                    have_w_q;

  logic                                    periodic_q;
  logic                                    single_q;
  logic                                    invert_q;
  logic                                    pass_all_q;
  logic [csi_tx_ctl_pkg::NUM_EV-1:0]       ie_q;
  logic [csi_tx_ctl_pkg::NUM_EV-1:0]       flags_q;
  logic                                    pass_q;
  logic                                    align_q;
  logic                                    err_block_q;
  logic [csi_tx_ctl_pkg::NUM_RX-1:0]       port_ok_q;
  logic                                    per_pend_q;
  logic                                    took_single_q;
  csi_tx_ctl_pkg::deskew_state_e           state_q;
  logic                                    deskew_req_q;
  logic [7:0]                              pattern_q;
  logic                                    irq_q;

  wire       aw_hs     = axil_req.awvalid & rsp_q.awready;
  wire       w_hs      = axil_req.wvalid & rsp_q.wready;
  wire       ar_hs     = axil_req.arvalid & rsp_q.arready;
  wire       wr_commit = have_aw_q & have_w_q & ~rsp_q.bvalid;
  wire [5:0] wr_idx    = reg_index(awaddr_q);
  wire [5:0] rd_idx    = reg_index(axil_req.araddr);

  wire       wr_ok     = wr_commit & wlane_q;
  wire       wr_ctl    = wr_ok & (wr_idx == csi_tx_ctl_pkg::IDX_CTL_TWO);
  wire       wr_ie     = wr_ok & (wr_idx == csi_tx_ctl_pkg::IDX_INT_EN);
  wire       rd_flags  = ar_hs & (rd_idx == csi_tx_ctl_pkg::IDX_INT_FLAGS);
  wire       single_wr = wr_ctl & wbyte_q[csi_tx_ctl_pkg::BIT_SINGLE];

  // ----------------------------------------------------------------------
  // Status levels
  // ----------------------------------------------------------------------
  wire [csi_tx_ctl_pkg::NUM_RX-1:0] port_ok = rx_port_enable & rx_port_valid;
  wire pass_any = |port_ok;
  wire pass_all = (|rx_port_enable) & ~|(rx_port_enable & ~rx_port_valid);

  wire pass_raw = pass_all_q ? pass_all : pass_any;
  // actively delivering; ready only when synchronized
  wire pass_d   = sync_enable ? pass_raw : (pass_raw & ~err_block_q & ~tx_error);
  // forced low without sync; follows alignment
  wire align_d  = sync_enable & align_ok;

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  logic [csi_tx_ctl_pkg::NUM_EV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[csi_tx_ctl_pkg::EV_VALID_GAIN]  = pass_d & ~pass_q;
    ev[csi_tx_ctl_pkg::EV_ALIGN_REACH] = align_d & ~align_q;

    // valid drops on a forwarded port
    ev[csi_tx_ctl_pkg::EV_VALID_LOSS]  = |(port_ok_q & ~port_ok);
    ev[csi_tx_ctl_pkg::EV_ALIGN_FAULT] = align_fail & sync_enable;

    // mirrored; cleared by the port's own status read
    ev[csi_tx_ctl_pkg::EV_RX_PORT]     = rx_port_event;
  end

  // Set wins over a clearing read in the same cycle
  // Port event bit is a live mirror; only the port can clear it
  wire [csi_tx_ctl_pkg::NUM_EV-1:0] clr_mask = rd_flags ? csi_tx_ctl_pkg::CLR_ON_RD : '0;
  wire [csi_tx_ctl_pkg::NUM_EV-1:0] flags_d  =
    {ev[csi_tx_ctl_pkg::EV_RX_PORT], (flags_q[3:0] & ~clr_mask[3:0]) | ev[3:0]};

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Flags bits 0 to 3 clear at the read address handshake
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      csi_tx_ctl_pkg::IDX_CTL_TWO:   rd_byte = {csi_tx_ctl_pkg::CTL_TWO_RSVD, pass_all_q, invert_q,
                                                single_q, periodic_q};
      csi_tx_ctl_pkg::IDX_STATUS:    rd_byte = {6'h00, align_q, pass_q};
      csi_tx_ctl_pkg::IDX_INT_EN:    rd_byte = {3'h0, ie_q};
      csi_tx_ctl_pkg::IDX_INT_FLAGS: rd_byte = {3'h0, flags_q};
      default:                       rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Address and data may arrive in either order; the response follows both
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rsp_q     <= '0;
      rsp_q.awready <= 1'b1;
      rsp_q.wready  <= 1'b1;
      rsp_q.arready <= 1'b1;
      awaddr_q  <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q  <= 1'b0;
    end else begin
      if (aw_hs) begin
        awaddr_q      <= axil_req.awaddr;
        have_aw_q     <= 1'b1;
        rsp_q.awready <= 1'b0;
      end

      if (w_hs) begin
        wbyte_q      <= axil_req.wdata[7:0];
        wlane_q      <= axil_req.wstrb[0];
        have_w_q     <= 1'b1;
        rsp_q.wready <= 1'b0;
      end

      if (wr_commit) begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp  <= mapped(wr_idx) ? csi_tx_ctl_pkg::RESP_OKAY : csi_tx_ctl_pkg::RESP_SLVERR;
      end else if (rsp_q.bvalid && axil_req.bready) begin
        rsp_q.bvalid  <= 1'b0;
        have_aw_q     <= 1'b0;
        have_w_q      <= 1'b0;
        rsp_q.awready <= 1'b1;
        rsp_q.wready  <= 1'b1;
      end

      if (ar_hs) begin
        rsp_q.arready <= 1'b0;
        rsp_q.rvalid  <= 1'b1;
        rsp_q.rdata   <= {24'h000000, rd_byte};
        rsp_q.rresp   <= mapped(rd_idx) ? csi_tx_ctl_pkg::RESP_OKAY : csi_tx_ctl_pkg::RESP_SLVERR;
      end else if (rsp_q.rvalid && axil_req.rready) begin
        rsp_q.rvalid  <= 1'b0;
        rsp_q.arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      periodic_q  <= 1'b0;
      invert_q    <= 1'b0;
      pass_all_q  <= 1'b0;
      ie_q        <= csi_tx_ctl_pkg::IE_RESET;
      flags_q     <= '0;
      pass_q      <= 1'b0;
      align_q     <= 1'b0;
      err_block_q <= 1'b0;
      port_ok_q   <= '0;
      irq_q       <= 1'b0;
    end else begin
      if (wr_ctl) begin
        periodic_q <= wbyte_q[csi_tx_ctl_pkg::BIT_PERIODIC];
        invert_q   <= wbyte_q[csi_tx_ctl_pkg::BIT_INVERT];
        pass_all_q <= wbyte_q[csi_tx_ctl_pkg::BIT_PASS_ALL];
      end

      if (wr_ie) begin
        ie_q <= wbyte_q[csi_tx_ctl_pkg::NUM_EV-1:0];
      end

      // error holds status low until the pass level drops
      err_block_q <= tx_error | (err_block_q & pass_raw);
      pass_q      <= pass_d;
      align_q     <= align_d;
      port_ok_q   <= port_ok;
      flags_q     <= flags_d;
      irq_q       <= |(flags_d & ie_q);
    end
  end

  // ----------------------------------------------------------------------
  // Deskew burst scheduler
  // ----------------------------------------------------------------------
  // A pending one-shot and a pending periodic burst share one burst
  wire burst_start = (state_q == csi_tx_ctl_pkg::DESKEW_IDLE) & (single_q | per_pend_q) & link_idle;
  wire burst_end   = (state_q == csi_tx_ctl_pkg::DESKEW_BURST) & deskew_done;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q       <= csi_tx_ctl_pkg::DESKEW_IDLE;
      single_q      <= 1'b0;
      per_pend_q    <= 1'b0;
      took_single_q <= 1'b0;
      deskew_req_q  <= 1'b0;
      pattern_q     <= csi_tx_ctl_pkg::PATTERN_NORMAL;
    end else begin
      pattern_q <= invert_q ? csi_tx_ctl_pkg::PATTERN_INVERT : csi_tx_ctl_pkg::PATTERN_NORMAL;

      // request after each Frame End while enabled
      if (frame_end_sent && periodic_q) begin
        per_pend_q <= 1'b1;
      end else if (burst_end || !periodic_q) begin
        per_pend_q <= 1'b0;
      end

      // one request, cleared once its burst is sent; a new write wins
      if (single_wr) begin
        single_q <= 1'b1;
      end else if (burst_end && took_single_q) begin
        single_q <= 1'b0;
      end

      unique case (state_q)
        csi_tx_ctl_pkg::DESKEW_IDLE: begin
          if (burst_start) begin
            state_q       <= csi_tx_ctl_pkg::DESKEW_BURST;
            deskew_req_q  <= 1'b1;
            took_single_q <= single_q;
          end
        end
        csi_tx_ctl_pkg::DESKEW_BURST: begin
          if (deskew_done) begin
            state_q       <= csi_tx_ctl_pkg::DESKEW_IDLE;
            deskew_req_q  <= 1'b0;
            took_single_q <= 1'b0;
          end else if (single_wr) begin
            // A one-shot written mid-burst is kept for the next burst
            took_single_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign axil_rsp       = rsp_q;
  assign deskew_req     = deskew_req_q;
  assign deskew_pattern = pattern_q;
  assign irq            = irq_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_burst_begins;
    (state_q == csi_tx_ctl_pkg::DESKEW_IDLE) && (single_q || per_pend_q) && link_idle;
  endsequence

  sequence s_single_served;
    burst_end && took_single_q && !single_wr;
  endsequence

  sequence s_error_hit;
    tx_error && !sync_enable;
  endsequence

  pass_any_a: assert property ((!pass_all_q && sync_enable && |port_ok) |=> pass_q)
    else $error("pass missing with one valid port");
  pass_all_a: assert property ((pass_all_q && |(rx_port_enable & ~rx_port_valid)) |=> !pass_q)
    else $error("pass raised with an enabled port invalid");

  pattern_norm_a: assert property (!invert_q |=> deskew_pattern == csi_tx_ctl_pkg::PATTERN_NORMAL)
    else $error("normal deskew pattern wrong");
  pattern_inv_a: assert property (invert_q |=> deskew_pattern == csi_tx_ctl_pkg::PATTERN_INVERT)
    else $error("inverted deskew pattern wrong");

  burst_idle_a: assert property ($rose(deskew_req) |-> $past(link_idle))
    else $error("burst started outside idle");
  burst_start_a: assert property (s_burst_begins |=> deskew_req)
    else $error("pending burst not started");
  single_clear_a: assert property (s_single_served |=> !single_q)
    else $error("one-shot bit did not clear");
  periodic_req_a: assert property ((frame_end_sent && periodic_q) |=> (per_pend_q || deskew_req))
    else $error("frame end did not schedule a burst");

  align_off_a: assert property (!sync_enable |=> !align_q)
    else $error("aligned status set with sync off");
  error_clear_a: assert property (s_error_hit |=> !pass_q [*2])
    else $error("valid status survived an error");
  loss_flag_a: assert property ((|(port_ok_q & ~port_ok)) |=> flags_q[csi_tx_ctl_pkg::EV_VALID_LOSS])
    else $error("valid loss not latched");
  irq_gate_a: assert property (|(flags_q & ie_q) |-> irq || $past(rd_flags) || $past(wr_ie))
    else $error("enabled flag without interrupt");

  align_on_a: assert property ((sync_enable && align_ok) |=> align_q)
    else $error("aligned status missing");
  gain_flag_a: assert property ($rose(pass_q) |-> flags_q[csi_tx_ctl_pkg::EV_VALID_GAIN])
    else $error("valid gain not latched");
  reach_flag_a: assert property ($rose(align_q) |-> flags_q[csi_tx_ctl_pkg::EV_ALIGN_REACH])
    else $error("alignment reached not latched");

  fault_flag_a: assert property ((align_fail && sync_enable) |=> flags_q[csi_tx_ctl_pkg::EV_ALIGN_FAULT])
    else $error("alignment fault not latched");
  port_mirror_a: assert property (rx_port_event |=> flags_q[csi_tx_ctl_pkg::EV_RX_PORT])
    else $error("port event not mirrored");

  periodic_off_a: assert property (!periodic_q |=> !per_pend_q)
    else $error("periodic burst pending while disabled");
  irq_release_a: assert property (irq |-> |(flags_q & $past(ie_q)))
    else $error("interrupt without an enabled flag");

endmodule : csi_tx_status_deskew_irq_ctl

/* tb/csi_link_model.sv */
/*
  Far-end link model: packet timing with Frame End, burst service and
  capture of the burst byte. Assumes the block asks for bursts on core_clk.
*/
`timescale 1ns/1ps
module csi_link_model (
  input  wire logic       core_clk,        // Clock
  input  wire logic       reset_n,         // Synchronous reset
  input  wire logic       send_frame,      // Start one packet
  input  wire logic       slow,            // Long burst service
  input  wire logic       deskew_req,      // Burst request
  input  wire logic [7:0] deskew_pattern,  // Burst byte
  output logic            link_idle,       // No packet in flight
  output logic            frame_end_sent,  // Frame End pulse
  output logic            deskew_done,     // Burst end pulse
  output int              burst_cnt,       // Bursts served
  output int              overlap_cnt,     // Bursts begun mid-packet
  output logic [7:0]      seen_pattern     // Byte of last burst
);
  int   pkt_q;
  int   svc_q;
  logic serving_q;

  assign link_idle = (pkt_q == 0);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pkt_q          <= 0;
      svc_q          <= 0;
      serving_q      <= 1'b0;
      burst_cnt      <= 0;
      overlap_cnt    <= 0;
      frame_end_sent <= 1'b0;
      deskew_done    <= 1'b0;
      seen_pattern   <= 8'h00;
    end else begin
      frame_end_sent <= (pkt_q == 1);
      deskew_done    <= 1'b0;
      if (send_frame) pkt_q <= 10;
      else if (pkt_q != 0) pkt_q <= pkt_q - 1;
      // Request still high in the cycle after done must not restart
      if (deskew_req && !serving_q && !deskew_done) begin
        serving_q    <= 1'b1;
        svc_q        <= slow ? 12 : 2;
        seen_pattern <= deskew_pattern;
        if (pkt_q != 0) overlap_cnt <= overlap_cnt + 1;
      end else if (serving_q && svc_q == 0) begin
        serving_q   <= 1'b0;
        deskew_done <= 1'b1;
        burst_cnt   <= burst_cnt + 1;
      end else if (serving_q) begin
        svc_q <= svc_q - 1;
      end
    end
  end
endmodule : csi_link_model

/* tb/csi_tx_status_deskew_irq_ctl_tb.sv */
/*
  Self-checking bench for the transmit-port control bank: bus tasks with a
  queue of expected answers, status, event and deskew scenarios.
  Assumes the design package and a 50 MHz core clock.
*/
`timescale 1ns/1ps
module csi_tx_status_deskew_irq_ctl_tb;
  localparam logic [7:0]  A_CTL = {csi_tx_ctl_pkg::IDX_CTL_TWO, 2'b00};
  localparam logic [7:0]  A_STS = {csi_tx_ctl_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0]  A_IE  = {csi_tx_ctl_pkg::IDX_INT_EN, 2'b00};
  localparam logic [7:0]  A_FLG = {csi_tx_ctl_pkg::IDX_INT_FLAGS, 2'b00};
  localparam logic [1:0]  OK    = csi_tx_ctl_pkg::RESP_OKAY;
  localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
  logic                      core_clk = 1'b0;
  logic                      reset_n  = 1'b0;
  csi_tx_ctl_pkg::axil_req_s req      = '0;
  csi_tx_ctl_pkg::axil_rsp_s rsp;
  logic [1:0]                en       = 2'b11;
  logic [1:0]                val      = 2'b00;
  logic [1:0]                e_en;
  logic                      sync_en  = 1'b0;
  logic                      al_ok    = 1'b0;
  logic                      al_fail  = 1'b0;
  logic                      tx_err   = 1'b0;
  logic                      port_ev  = 1'b0;
  logic                      send_frame = 1'b0;
  logic                      slow     = 1'b0;
  logic                      idle, fe, done, dreq, irq;
  logic [7:0]                pat, seen;
  logic [31:0]               r;
  logic [65:0]               e_mon;
  logic [65:0]               exp_q[$];
  int                        bursts, overlaps;
  int                        error_cnt  = 0;
  int                        n_compared = 0;

  always #10 core_clk = ~core_clk;

  csi_tx_status_deskew_irq_ctl csi_tx_status_deskew_irq_ctl_i (
    .core_clk(core_clk), .reset_n(reset_n), .axil_req(req), .axil_rsp(rsp),
    .rx_port_enable(en), .rx_port_valid(val), .sync_enable(sync_en), .align_ok(al_ok),
    .align_fail(al_fail), .tx_error(tx_err), .rx_port_event(port_ev), .frame_end_sent(fe),
    .link_idle(idle), .deskew_done(done), .deskew_req(dreq), .deskew_pattern(pat), .irq(irq));

  csi_link_model csi_link_model_i (
    .core_clk(core_clk), .reset_n(reset_n), .send_frame(send_frame), .slow(slow),
    .deskew_req(dreq), .deskew_pattern(pat), .link_idle(idle), .frame_end_sent(fe),
    .deskew_done(done), .burst_cnt(bursts), .overlap_cnt(overlaps), .seen_pattern(seen));

  task automatic check(input string nm, input logic [33:0] exp, input logic [33:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    exp_q.push_back({32'h0, OK, 32'h0});
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] s);
    exp_q.push_back({m, s, d & m});
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic wait_bursts(input int n);
    for (int i = 0; i < 400 && bursts != n; i++) @(posedge core_clk);
    check("burst count", 34'(n), 34'(bursts));
  endtask : wait_bursts

  task automatic frame();
    send_frame <= 1'b1;
    @(posedge core_clk);
    send_frame <= 1'b0;
  endtask : frame

  // Oldest note is taken as each answer is handed over
  always @(posedge core_clk) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      e_mon = exp_q.pop_front();
      check("bus answer", e_mon[33:0],
            {rsp.bvalid ? rsp.bresp : rsp.rresp, (rsp.bvalid ? 32'h0 : rsp.rdata) & e_mon[65:34]});
    end
  end

  // Far beyond the expected run of some four hundred cycles
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h9322c99b));
    tick(12);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check("pattern", 34'(csi_tx_ctl_pkg::PATTERN_NORMAL), 34'(pat));
    check("irq", 34'(1'b0), 34'(irq));
    rd(A_CTL, 32'h40, ALL, OK);
    rd(A_STS, 32'h0, ALL, OK);
    rd(A_FLG, 32'h0, ALL, OK);
    rd(8'hE0, 32'h0, ALL, csi_tx_ctl_pkg::RESP_SLVERR);
    r = $urandom;
    wr(A_IE, r, 4'hF);
    rd(A_IE, r & 32'h1F, ALL, OK);
    wr(A_IE, ~r, 4'h0);
    rd(A_IE, r & 32'h1F, ALL, OK);
    wr(A_IE, 32'h0, 4'hF);
    $display("map test done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      e_en = (r[1:0] == 2'b00) ? 2'b01 : r[1:0];
      en <= e_en;
      val <= r[3:2];
      wr(A_CTL, {28'h0, r[4], 3'h0}, 4'hF);
      rd(A_STS, {31'h0, r[4] ? ((e_en & r[3:2]) == e_en) : |(e_en & r[3:2])}, ALL, OK);
    end
    en <= 2'b11;
    val <= 2'b00;
    wr(A_CTL, 32'h0, 4'hF);
    rd(A_FLG, 32'h0, 32'h0, OK);
    $display("pass scope test done");
    val <= 2'b01;
    tick(3);
    check("irq", 34'(1'b0), 34'(irq));
    rd(A_FLG, 32'h01, ALL, OK);
    wr(A_IE, 32'h03, 4'hF);
    val <= 2'b00;
    tick(3);
    check("irq", 34'(1'b1), 34'(irq));
    rd(A_FLG, 32'h02, ALL, OK);
    check("irq", 34'(1'b0), 34'(irq));
    wr(A_IE, 32'h0C, 4'hF);
    sync_en <= 1'b1;
    al_ok <= 1'b1;
    tick(3);
    check("irq", 34'(1'b1), 34'(irq));
    rd(A_STS, 32'h02, ALL, OK);
    rd(A_FLG, 32'h04, ALL, OK);
    check("irq", 34'(1'b0), 34'(irq));
    al_fail <= 1'b1;
    @(posedge core_clk);
    al_fail <= 1'b0;
    tick(2);
    check("irq", 34'(1'b1), 34'(irq));
    rd(A_FLG, 32'h08, ALL, OK);
    sync_en <= 1'b0;
    tick(2);
    rd(A_STS, 32'h00, ALL, OK);
    al_ok <= 1'b0;
    wr(A_IE, 32'h10, 4'hF);
    port_ev <= 1'b1;
    tick(3);
    check("irq", 34'(1'b1), 34'(irq));
    rd(A_FLG, 32'h10, ALL, OK);
    rd(A_FLG, 32'h10, ALL, OK);
    port_ev <= 1'b0;
    tick(3);
    check("irq", 34'(1'b0), 34'(irq));
    wr(A_IE, 32'h0, 4'hF);
    $display("event test done");
    val <= 2'b01;
    tick(3);
    tx_err <= 1'b1;
    @(posedge core_clk);
    tx_err <= 1'b0;
    tick(2);
    rd(A_STS, 32'h00, ALL, OK);
    val <= 2'b00;
    tick(2);
    val <= 2'b01;
    sync_en <= 1'b1;
    tick(2);
    rd(A_STS, 32'h01, ALL, OK);
    sync_en <= 1'b0;
    val <= 2'b00;
    rd(A_FLG, 32'h0, 32'h0, OK);
    $display("error test done");
    wr(A_CTL, 32'h04, 4'hF);
    check("pattern", 34'(csi_tx_ctl_pkg::PATTERN_INVERT), 34'(pat));
    wr(A_CTL, 32'h00, 4'hF);
    check("pattern", 34'(csi_tx_ctl_pkg::PATTERN_NORMAL), 34'(pat));
    frame();
    wr(A_CTL, 32'h02, 4'hF);
    check("burst request", 34'(1'b0), 34'(dreq));
    wait_bursts(1);
    rd(A_CTL, 32'h40, ALL, OK);
    tick(40);
    check("burst count", 34'(1), 34'(bursts));
    check("seen pattern", 34'(csi_tx_ctl_pkg::PATTERN_NORMAL), 34'(seen));
    slow <= 1'b1;
    wr(A_CTL, 32'h05, 4'hF);
    for (int i = 0; i < 3; i++) begin
      frame();
      wait_bursts(2 + i);
    end
    check("seen pattern", 34'(csi_tx_ctl_pkg::PATTERN_INVERT), 34'(seen));
    wr(A_CTL, 32'h00, 4'hF);
    frame();
    tick(60);
    check("burst count", 34'(4), 34'(bursts));
    check("overlaps", 34'(0), 34'(overlaps));
    $display("deskew test done");
    complete_run();
  end
endmodule : csi_tx_status_deskew_irq_ctl_tb
